// *** verification/hpdc_host_port.sv ***
/*
 * Upstream host model that starts a port power-on sequence and times it.
 * Assumes the block clock and a one-cycle go request from the bench.
 */
`timescale 1ns/100ps
module hpdc_host_port (
  input wire logic aclk,
  input wire logic go,
  input wire logic [1:0] port,
  output logic [3:0] port_power_start,
  input wire logic [3:0] port_power_good,
  output int wait_cycles,
  output logic done
);
  // Pulse one start for a single cycle, then count cycles until power good.
  initial begin
    port_power_start = 4'h0;
    wait_cycles = 0;
    done = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        port_power_start[port] <= 1'b1;
        done <= 1'b0;
        wait_cycles <= 0;
        @(posedge aclk);
        port_power_start <= 4'h0;
        // Falling-edge polling keeps the sample clear of rising-edge updates.
        forever begin
          @(negedge aclk);
          if (port_power_good[port]) break;
          wait_cycles <= wait_cycles + 1;
        end
        done <= 1'b1;
      end
    end
  end
endmodule

// *** verification/tb.sv ***
/*
 * Self-checking bench for the hub power descriptor registers.
 * Assumes a 20 MHz clock and a shortened settle tick of 4 cycles.
 */
`timescale 1ns/100ps
module tb;
  localparam int T = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, self_powered, go, done;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, dmp, dcc, dst;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, start, good;
  logic [1:0] bresp, rresp, port, rs;
  logic [15:0] dlid;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int wc;
  // Rows: byte address, reset value, value written and read back.
  logic [7:0] ra[7] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48};
  logic [7:0] rr[7] = '{8'h00, 8'h32, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00};
  logic [7:0] rw[7] = '{8'h19, 8'h2d, 8'h0a, 8'h40, 8'h03, 8'h04, 8'h09};

  hpdc_config_regs #(.TICK_CYCLES(T)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .self_powered(self_powered), .port_power_start(start), .port_power_good(good),
    .desc_max_power(dmp), .desc_controller_current(dcc), .desc_settle_time(dst),
    .desc_language_id(dlid));
  hpdc_host_port host_u (.aclk(aclk), .go(go), .port(port), .port_power_start(start),
    .port_power_good(good), .wait_cycles(wc), .done(done));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling far above the 150 or so cycles the run needs.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; unknowns never match.
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Address and data go out together; each drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic ha, hw, hb;
    @(posedge aclk); // Drive on a rising edge and leave an edge between calls.
    awaddr <= a;
    wdata <= {24'ha5a5a5, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // Read one word; the answer is taken at the edge where rvalid is seen.
  task automatic rdw(input logic [7:0] a);
    logic ha, hv;
    @(posedge aclk); // Drive on a rising edge and leave an edge between calls.
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = arvalid && arready;
      hv = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hv) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Start port 2 through the host model and wait until its power is good.
  task automatic settle();
    @(posedge aclk);
    port <= 2'h2;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(negedge aclk);
    while (!done) @(negedge aclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table rows first, then the awkward cases.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, self_powered, go} = 8'h00;
    {awaddr, araddr, wdata, wstrb, port} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rdw(ra[i]);
      chk("reset value", rd, {24'h0, rr[i]});
    end
    // Self-powered bytes are kept below the 100 mA figure.
    // No compound peripheral is attached, so no draw is added to them.
    for (int i = 0; i < 7; i++) begin
      wr(ra[i], rw[i], 4'h1);
      chk("bresp", {30'h0, rs}, {30'h0, hpdc_pkg::RESP_OKAY});
      rdw(ra[i]);
      chk("readback", rd, {24'h0, rw[i]});
    end
    @(negedge aclk);
    chk("bus max power", {24'h0, dmp}, 32'h2d);
    chk("bus ctrl current", {24'h0, dcc}, 32'h40);
    chk("settle byte", {24'h0, dst}, 32'h03);
    chk("language id", {16'h0, dlid}, 32'h0409);
    @(posedge aclk);
    self_powered <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("self max power", {24'h0, dmp}, 32'h19);
    chk("self ctrl current", {24'h0, dcc}, 32'h0a);
    // A write with its byte strobe off must leave the register alone.
    wr(8'h30, 8'h7f, 4'h0);
    rdw(8'h30);
    chk("masked write", rd, 32'h19);
    // An unmapped address stores nothing and reads as zero.
    wr(8'h4c, 8'h77, 4'h1);
    chk("bresp unmapped", {30'h0, rs}, {30'h0, hpdc_pkg::RESP_SLVERR});
    rdw(8'h4c);
    chk("rdata unmapped", rd, 32'h0);
    chk("rresp unmapped", {30'h0, rs}, {30'h0, hpdc_pkg::RESP_SLVERR});
    // The second run restarts a port whose power is already good.
    repeat (2) begin
      settle();
      chk("settle wait", {31'h0, wc >= 3 * T && wc <= 4 * T + 2}, 32'h1);
    end
    rdw(8'h80);
    chk("status", rd, 32'h09);
    // A reset in mid-run brings the bus-powered default back.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(8'h34);
    chk("reset again", rd, 32'h32);
    // The settle byte is zero again, so power good follows within two cycles.
    settle();
    chk("zero settle", {31'h0, wc >= 1 && wc <= 2}, 32'h1);
    wrap_up();
  end
endmodule

// *** verilog/hpdc_config_regs.sv ***
/*
 * Hub power descriptor configuration registers behind an AXI4-Lite slave.
 * Drives the values the descriptor logic reports to the upstream host and
 * runs the port power settle timer. Assumes one clock, synchronous inputs.
 */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// (RL1) Self-powered max power in 2 mA units.
// (RL2) Configurer adds zero-current compound peripheral draw.
// (RL3) Bus-powered max power in 2 mA units.
// (RL4) Bus-powered max power resets to 50.
// (RL5) Configurer keeps self-powered values at 100 mA.
// (RL6) Self-powered controller current in 2 mA.
// (RL7) Bus-powered controller current, resets to 50.
// (RL8) Settle time counts 2 ms intervals per port.
// (RL9) Language ID: high byte upper, low lower.
// (RL10) Power mode selects reported current values.
module hpdc_config_regs #(
  parameter int unsigned TICK_CYCLES = hpdc_pkg::SETTLE_UNIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [hpdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [hpdc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hpdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [hpdc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic self_powered,
  input wire logic [hpdc_pkg::NUM_PORTS-1:0] port_power_start,
  output logic [hpdc_pkg::NUM_PORTS-1:0] port_power_good,
  output logic [7:0] desc_max_power,
  output logic [7:0] desc_controller_current,
  output logic [7:0] desc_settle_time,
  output logic [15:0] desc_language_id
);
  localparam int unsigned IW = hpdc_pkg::IDX_W;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // True when a byte address selects the register of the given index.
  function automatic logic idx_hit(input logic [hpdc_pkg::ADDR_W-1:0] addr,
                                   input logic [IW-1:0] idx);
    return addr[hpdc_pkg::ADDR_W-1:2] == idx;
  endfunction

  // True for every address that holds a register; the config bytes are contiguous.
  function automatic logic addr_mapped(input logic [hpdc_pkg::ADDR_W-1:0] addr);
    return (addr[hpdc_pkg::ADDR_W-1:2] >= hpdc_pkg::IDX_SP_MAX_POWER &&
            addr[hpdc_pkg::ADDR_W-1:2] <= hpdc_pkg::IDX_LANG_LOW) ||
           idx_hit(addr, hpdc_pkg::IDX_STATUS);
  endfunction
  hpdc_timer_if tif ();

  //////////////////////////////////////////////////////////////////////////////
  // Write channel state.
  hpdc_pkg::hpdc_ch_state_t wr_state_reg;
  hpdc_pkg::hpdc_ch_state_t wr_state_next;
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [hpdc_pkg::ADDR_W-1:0] waddr_reg;
  logic [hpdc_pkg::ADDR_W-1:0] waddr_next;
  logic [7:0] wbyte_reg;
  logic [7:0] wbyte_next;
  logic wlane_reg;
  logic wlane_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic wr_commit;

  assign s_axi_awready = !aw_held_reg && wr_state_reg == hpdc_pkg::HPDC_CH_IDLE;
  assign s_axi_wready = !w_held_reg && wr_state_reg == hpdc_pkg::HPDC_CH_IDLE;
  assign s_axi_bvalid = wr_state_reg == hpdc_pkg::HPDC_CH_RESP;
  assign s_axi_bresp = bresp_reg;
  // Address and data may arrive in either order; the write acts once both are in.
  assign wr_commit = aw_held_reg && w_held_reg;

  // Only byte lane 0 carries register data, so only its strobe matters.
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    case (wr_state_reg)
      hpdc_pkg::HPDC_CH_IDLE: begin
        if (wr_commit) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wr_state_next = hpdc_pkg::HPDC_CH_RESP;
          bresp_next = addr_mapped(waddr_reg) ? hpdc_pkg::RESP_OKAY : hpdc_pkg::RESP_SLVERR;
        end
      end
      hpdc_pkg::HPDC_CH_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = hpdc_pkg::HPDC_CH_IDLE;
        end
      end
      default: begin
        wr_state_next = hpdc_pkg::HPDC_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= hpdc_pkg::HPDC_CH_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bresp_reg <= hpdc_pkg::RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bresp_reg <= bresp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers. Ranges are not clamped: keeping the self-powered
  // bytes within the bus limit is left to software. [RL5]
  logic [7:0] sp_max_power_reg;
  logic [7:0] sp_max_power_next;
  logic [7:0] bp_max_power_reg;
  logic [7:0] bp_max_power_next;
  logic [7:0] sp_ctrl_current_reg;
  logic [7:0] sp_ctrl_current_next;
  logic [7:0] bp_ctrl_current_reg;
  logic [7:0] bp_ctrl_current_next;
  logic [7:0] settle_time_reg;
  logic [7:0] settle_time_next;
  logic [7:0] lang_high_reg;
  logic [7:0] lang_high_next;
  logic [7:0] lang_low_reg;
  logic [7:0] lang_low_next;
  logic wr_lane0;

  assign wr_lane0 = wr_commit && wr_state_reg == hpdc_pkg::HPDC_CH_IDLE && wlane_reg;

  // Stored bytes are the raw 2 mA and 2 ms figures with no conversion. [RL1] [RL3] [RL6]
  always_comb begin
    sp_max_power_next = sp_max_power_reg;
    bp_max_power_next = bp_max_power_reg;
    sp_ctrl_current_next = sp_ctrl_current_reg;
    bp_ctrl_current_next = bp_ctrl_current_reg;
    settle_time_next = settle_time_reg;
    lang_high_next = lang_high_reg;
    lang_low_next = lang_low_reg;
    if (wr_lane0) begin
      if (idx_hit(waddr_reg, hpdc_pkg::IDX_SP_MAX_POWER)) begin
        sp_max_power_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_BP_MAX_POWER)) begin
        bp_max_power_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_SP_CTRL_CURRENT)) begin
        sp_ctrl_current_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_BP_CTRL_CURRENT)) begin
        bp_ctrl_current_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_SETTLE_TIME)) begin
        settle_time_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_LANG_HIGH)) begin
        lang_high_next = wbyte_reg;
      end else if (idx_hit(waddr_reg, hpdc_pkg::IDX_LANG_LOW)) begin
        lang_low_next = wbyte_reg;
      end
    end
  end

  // Both bus-powered figures come up at 100 mA. [RL4] [RL7]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_max_power_reg <= hpdc_pkg::RST_SP_MAX_POWER;
      bp_max_power_reg <= hpdc_pkg::RST_BP_MAX_POWER;
      sp_ctrl_current_reg <= hpdc_pkg::RST_SP_CTRL_CURRENT;
      bp_ctrl_current_reg <= hpdc_pkg::RST_BP_CTRL_CURRENT;
      settle_time_reg <= hpdc_pkg::RST_SETTLE_TIME;
      lang_high_reg <= hpdc_pkg::RST_LANG_HIGH;
      lang_low_reg <= hpdc_pkg::RST_LANG_LOW;
    end else begin
      sp_max_power_reg <= sp_max_power_next;
      bp_max_power_reg <= bp_max_power_next;
      sp_ctrl_current_reg <= sp_ctrl_current_next;
      bp_ctrl_current_reg <= bp_ctrl_current_next;
      settle_time_reg <= settle_time_next;
      lang_high_reg <= lang_high_next;
      lang_low_reg <= lang_low_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel.
  hpdc_pkg::hpdc_ch_state_t rd_state_reg;
  hpdc_pkg::hpdc_ch_state_t rd_state_next;
  logic [hpdc_pkg::DATA_W-1:0] rdata_reg;
  logic [hpdc_pkg::DATA_W-1:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [7:0] rd_byte;
  logic [hpdc_pkg::DATA_W-1:0] status_word;

  assign s_axi_arready = rd_state_reg == hpdc_pkg::HPDC_CH_IDLE;
  assign s_axi_rvalid = rd_state_reg == hpdc_pkg::HPDC_CH_RESP;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Status shows the live power mode and each port's settle state.
  always_comb begin
    status_word = '0;
    status_word[hpdc_pkg::STAT_MODE_BIT] = self_powered;
    status_word[hpdc_pkg::STAT_GOOD_LSB +: hpdc_pkg::NUM_PORTS] = tif.good;
  end

  // Byte registers sit in the low lane; upper bits read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_SP_MAX_POWER)) begin
      rd_byte = sp_max_power_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_BP_MAX_POWER)) begin
      rd_byte = bp_max_power_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_SP_CTRL_CURRENT)) begin
      rd_byte = sp_ctrl_current_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_BP_CTRL_CURRENT)) begin
      rd_byte = bp_ctrl_current_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_SETTLE_TIME)) begin
      rd_byte = settle_time_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_LANG_HIGH)) begin
      rd_byte = lang_high_reg;
    end else if (idx_hit(s_axi_araddr, hpdc_pkg::IDX_LANG_LOW)) begin
      rd_byte = lang_low_reg;
    end
  end

  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      hpdc_pkg::HPDC_CH_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_next = hpdc_pkg::HPDC_CH_RESP;
          rresp_next = addr_mapped(s_axi_araddr) ? hpdc_pkg::RESP_OKAY : hpdc_pkg::RESP_SLVERR;
          rdata_next = idx_hit(s_axi_araddr, hpdc_pkg::IDX_STATUS) ? status_word :
                       {{(hpdc_pkg::DATA_W - 8){1'b0}}, rd_byte};
        end
      end
      hpdc_pkg::HPDC_CH_RESP: begin
        if (s_axi_rready) begin
          rd_state_next = hpdc_pkg::HPDC_CH_IDLE;
        end
      end
      default: begin
        rd_state_next = hpdc_pkg::HPDC_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= hpdc_pkg::HPDC_CH_IDLE;
      rdata_reg <= '0;
      rresp_reg <= hpdc_pkg::RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Descriptor values. A compound peripheral's draw is not added here; the
  // configured byte is reported as written. [RL2]
  logic [7:0] max_power_next;
  logic [7:0] ctrl_current_next;

  // The present power mode picks which pair the host sees. [RL10]
  always_comb begin
    max_power_next = self_powered ? sp_max_power_reg : bp_max_power_reg;
    ctrl_current_next = self_powered ? sp_ctrl_current_reg : bp_ctrl_current_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_max_power <= hpdc_pkg::RST_BP_MAX_POWER;
      desc_controller_current <= hpdc_pkg::RST_BP_CTRL_CURRENT;
      desc_settle_time <= hpdc_pkg::RST_SETTLE_TIME;
      desc_language_id <= {hpdc_pkg::RST_LANG_HIGH, hpdc_pkg::RST_LANG_LOW};
    end else begin
      desc_max_power <= max_power_next;
      desc_controller_current <= ctrl_current_next;
      desc_settle_time <= settle_time_reg; // [RL8]
      desc_language_id <= {lang_high_reg, lang_low_reg}; // [RL9]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port settle timing.
  assign tif.settle_time = settle_time_reg; // [RL8]
  assign tif.start = port_power_start;
  assign port_power_good = tif.good;

  hpdc_settle_timer #(.TICK_CYCLES(TICK_CYCLES)) u_settle_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_bp_power_reset: assert property ($past(!aresetn) |-> // [RL4]
    bp_max_power_reg == hpdc_pkg::RST_BP_MAX_POWER)
    else $error("Bus-powered max power did not come up at 50.");
  chk_bp_current_reset: assert property ($past(!aresetn) |-> // [RL7]
    bp_ctrl_current_reg == hpdc_pkg::RST_BP_CTRL_CURRENT)
    else $error("Bus-powered controller current did not come up at 50.");
  chk_sp_power_select: assert property (self_powered |=> // [RL1]
    desc_max_power == $past(sp_max_power_reg))
    else $error("Self-powered mode did not report the self-powered max power.");
  chk_bp_power_select: assert property (!self_powered |=> // [RL3]
    desc_max_power == $past(bp_max_power_reg))
    else $error("Bus-powered mode did not report the bus-powered max power.");
  chk_current_select: assert property (1'b1 |=> desc_controller_current == // [RL6]
    ($past(self_powered) ? $past(sp_ctrl_current_reg) : $past(bp_ctrl_current_reg)))
    else $error("Controller current did not follow the power mode.");
  chk_lang_id_order: assert property ($rose(s_axi_bvalid) && wlane_reg && // [RL9]
    idx_hit(waddr_reg, hpdc_pkg::IDX_LANG_HIGH) |=>
    desc_language_id == {$past(wbyte_reg), $past(lang_low_reg)})
    else $error("High language byte did not land in the upper half.");
  chk_bp_write_lands: assert property ($rose(s_axi_bvalid) && wlane_reg && // [RL3]
    idx_hit(waddr_reg, hpdc_pkg::IDX_BP_MAX_POWER) |-> bp_max_power_reg == wbyte_reg)
    else $error("Bus-powered max power write was not stored.");
  chk_settle_reported: assert property ($rose(s_axi_bvalid) && wlane_reg && // [RL8]
    idx_hit(waddr_reg, hpdc_pkg::IDX_SETTLE_TIME) |=>
    desc_settle_time == $past(wbyte_reg))
    else $error("Settle time write did not reach the descriptor.");
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before it was taken.");
endmodule

// *** verilog/hpdc_pkg.sv ***
/*
 * Shared constants for the hub power descriptor configuration block:
 * register indices, reset values, units and bus answer codes.
 * Assumes one 20 MHz clock; byte address of a register is four times its index.
 */
package hpdc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned NUM_PORTS = 4;
  // Register indices; the byte address is the index times four.
  localparam logic [IDX_W-1:0] IDX_SP_MAX_POWER = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_BP_MAX_POWER = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_SP_CTRL_CURRENT = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_BP_CTRL_CURRENT = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_SETTLE_TIME = 6'h10;
  localparam logic [IDX_W-1:0] IDX_LANG_HIGH = 6'h11;
  localparam logic [IDX_W-1:0] IDX_LANG_LOW = 6'h12;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
  // Reset values.
  localparam logic [7:0] RST_SP_MAX_POWER = 8'h00;
  localparam logic [7:0] RST_BP_MAX_POWER = 8'h32;
  localparam logic [7:0] RST_SP_CTRL_CURRENT = 8'h00;
  localparam logic [7:0] RST_BP_CTRL_CURRENT = 8'h32;
  localparam logic [7:0] RST_SETTLE_TIME = 8'h00;
  localparam logic [7:0] RST_LANG_HIGH = 8'h00;
  localparam logic [7:0] RST_LANG_LOW = 8'h00;
  // Status register field positions.
  localparam int unsigned STAT_MODE_BIT = 0;
  localparam int unsigned STAT_GOOD_LSB = 1;
  // Units and timing.
  localparam int unsigned CURRENT_UNIT_MA = 2;
  localparam int unsigned SETTLE_UNIT_MS = 2;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SETTLE_UNIT_CYCLES = CLK_HZ / 1000 * SETTLE_UNIT_MS;
  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {HPDC_CH_IDLE = 1'b0, HPDC_CH_RESP = 1'b1} hpdc_ch_state_t;
endpackage

// *** verilog/hpdc_settle_timer.sv ***
/*
 * Per-port power settle timer counting in 2 ms ticks.
 * Assumes start pulses are one cycle wide and synchronous to aclk.
 */
`timescale 1ns/100ps
module hpdc_settle_timer #(
  parameter int unsigned TICK_CYCLES = hpdc_pkg::SETTLE_UNIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  hpdc_timer_if.timer tif
);
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE = 9'h001;

  logic [TW-1:0] div_reg;
  logic [TW-1:0] div_next;
  logic tick;

  //////////////////////////////////////////////////////////////////////////////
  // Free-running divider; one tick per settle unit.
  assign tick = (div_reg == TICK_LAST);

  always_comb begin
    div_next = tick ? '0 : div_reg + TW'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One counter per port. The tick runs free, so the first interval may be
  // partial; a nonzero setting loads one extra tick so the wait is never shorter than asked.
  genvar gi;
  generate
    for (gi = 0; gi < hpdc_pkg::NUM_PORTS; gi++) begin : g_port
      logic [8:0] cnt_reg;
      logic [8:0] cnt_next;
      logic active_reg;
      logic active_next;
      logic good_reg;
      logic good_next;

      // Start loads the count, zero count ends the sequence. [RL8]
      always_comb begin
        cnt_next = cnt_reg;
        active_next = active_reg;
        good_next = good_reg;
        if (tif.start[gi]) begin
          cnt_next = (tif.settle_time == 8'h00) ? CNT_ZERO : {1'b0, tif.settle_time} + CNT_ONE;
          active_next = 1'b1;
          good_next = 1'b0;
        end else if (active_reg && cnt_reg == CNT_ZERO) begin
          active_next = 1'b0;
          good_next = 1'b1;
        end else if (active_reg && tick) begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_reg <= CNT_ZERO;
          active_reg <= 1'b0;
          good_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          active_reg <= active_next;
          good_reg <= good_next;
        end
      end

      assign tif.good[gi] = good_reg;

      chk_zero_settle_good: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
        tif.start[gi] && tif.settle_time == 8'h00 ##1 !tif.start[gi] |=> good_reg)
        else $error("Zero settle time did not give power good after two cycles.");

      chk_start_clears_good: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
        tif.start[gi] |=> !good_reg && active_reg)
        else $error("Port start did not restart the settle sequence.");
    end
  endgenerate
endmodule

// *** verilog/hpdc_timer_if.sv ***
/*
 * Link between the configuration registers and the port settle timer.
 * Assumes both ends share the block clock.
 */
`timescale 1ns/100ps
interface hpdc_timer_if;
  logic [7:0] settle_time;
  logic [hpdc_pkg::NUM_PORTS-1:0] start;
  logic [hpdc_pkg::NUM_PORTS-1:0] good;
  modport ctrl (output settle_time, output start, input good);
  modport timer (input settle_time, input start, output good);
endinterface
